/* File: rtl/slave_address_param_service.v */
// address-change and parameter telegram service with apb register access
// assumes a frame receiver on pclk delivering checked payload bytes
//
// Chosen here: the APB register port.
`timescale 1ns/1ns
`include "slave_service_regs.vh"
// Functional notes
// - good address telegram: store payload, swap buffers, record length
// - on accept raise new-address flag, adopt address and no-change flag
// - read of release location returns zero and re-arms the service
// - faulty address telegrams are dropped without swap or flag
// - buffer bytes: address, ident high, ident low, no-change, app data
// - parameter decode uses seven bytes, eight with user data, or ten with extensions on
// - bytes 0..6: status, factors, responder delay, ident, group
// - byte 7 is the device byte; later bytes, except 8 and 9 with extensions on, belong to the application
// - spec bit 7 enables protocol extensions, default off
// - spec bit 6 enables fail-safe mode, default off
// - spec bit 5 enables the publisher function, default off
// - spec bit 2 selects watchdog base: 10 ms clear, 1 ms set
// - spec bit 1 disables stop-bit checking in the receiver
// - spec bit 0 disables start-bit checking in the receiver
// - with extensions on, bytes 8 and 9 are the extension status bytes
// - timeout equals time base times both watchdog factors
// - watchdog enable bit selects response-time monitoring
// - telegram exceeding buffer capacity gets a no-resources answer
// - parameter telegram over seven bytes: swap, length, new-data flag
module slave_address_param_service #(
  parameter [16:0] MS_CYCLES = `WD_MS_CYCLES
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire rx_start,
  input wire rx_service,
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_end,
  input wire rx_good,
  output reg resp_ack,
  output reg resp_no_resources,
  output wire new_address_data_interrupt,
  output wire new_prm_data_interrupt,
  output wire [7:0] station_address,
  output wire [7:0] no_change_flag,
  output wire extensions_enable,
  output wire fail_safe_enable,
  output wire publisher_enable,
  output wire watchdog_time_base,
  output wire stop_check_disable,
  output wire start_check_disable,
  output wire response_monitoring,
  output wire wd_timeout
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_RECV = 2'h1;
  localparam [1:0] ST_DROP = 2'h2;
  reg [1:0] state_reg;
  reg svc_reg;
  reg [7:0] idx_reg;
  reg ovf_reg;
  reg [7:0] acb_ptr_reg;
  reg [7:0] station_reg;
  reg [7:0] nochg_reg;
  reg [7:0] acb_len_reg;
  reg [7:0] prm_len_reg;
  reg [7:0] acb_cap_reg;
  reg [7:0] prm_cap_reg;
  reg ssa_pending_reg;
  reg prm_pending_reg;
  reg [7:0] prm_status_reg;
  reg [7:0] f1_reg;
  reg [7:0] f2_reg;
  reg [7:0] min_responder_delay_reg;
  reg [15:0] ident_reg;
  reg [7:0] group_reg;
  reg [7:0] spec_reg;
  reg [7:0] ext2_reg;
  reg [7:0] ext3_reg;
  reg [31:0] prdata_reg;
  reg [31:0] rd_mux;
  reg mapped;
  reg [7:0] shadow [0:`PRM_SHADOW-1];
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr_acc = access & pwrite & mapped;
  wire rd_acc = access & ~pwrite & mapped;
  wire [1:0] win = paddr[11:10];
  wire [7:0] widx = paddr[9:2];
  wire win_ok = (paddr[1:0] == 2'h0) && (widx < `BUF_DEPTH);
  wire [7:0] acb_rd;
  wire [7:0] prm_rd;
  wire release_rd = rd_acc && (paddr == `OFS_RELEASE);
  wire prm_ack_rd = rd_acc && (paddr == `OFS_PRM_ACK);
  wire [7:0] cap = (svc_reg == `SVC_PRM) ? prm_cap_reg : acb_cap_reg;
  wire store = (state_reg == ST_RECV) && rx_valid && (idx_reg < cap);
  wire fin = (state_reg == ST_RECV) && rx_end;
  wire fin_good = fin && rx_good && !ovf_reg;
  wire acb_busy = ssa_pending_reg && !release_rd;
  wire acb_accept = fin_good && (svc_reg == `SVC_ADDR) && !acb_busy;
  wire prm_ok = fin_good && (svc_reg == `SVC_PRM) && (idx_reg >= `PRM_BASE_LEN);
  wire prm_swap = prm_ok && (idx_reg > `PRM_BASE_LEN);
  wire nores = fin && rx_good && (ovf_reg || ((svc_reg == `SVC_ADDR) && acb_busy));
  wire has_spec = (idx_reg > `PRM_BASE_LEN);
  wire [7:0] spec_new = has_spec ? shadow[`PRM_SPEC] : 8'h00;
  // captured header bytes, so decode does not need a buffer read port
  genvar gi;
  generate
    for (gi = 0; gi < `PRM_SHADOW; gi = gi + 1) begin : g_shadow
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          shadow[gi] <= 8'h00;
        end else if (store && (idx_reg == gi)) begin
          shadow[gi] <= rx_data;
        end
      end
    end
  endgenerate
  swap_buffer u_acb (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(store && (svc_reg == `SVC_ADDR)),
    .wr_idx(idx_reg),
    .wr_data(rx_data),
    .swap(acb_accept),
    .rd_idx(widx),
    .rd_data(acb_rd)
  );
  swap_buffer u_prm (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(store && (svc_reg == `SVC_PRM)),
    .wr_idx(idx_reg),
    .wr_data(rx_data),
    .swap(prm_swap),
    .rd_idx(widx),
    .rd_data(prm_rd)
  );
  monitor_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .enable(response_monitoring),
    .fine_base(watchdog_time_base),
    .factor_one(f1_reg),
    .factor_two(f2_reg),
    .retrigger(fin && rx_good),
    .timeout(wd_timeout)
  );
  // telegram reception
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      svc_reg <= `SVC_ADDR;
      idx_reg <= 8'h00;
      ovf_reg <= 1'b0;
      resp_ack <= 1'b0;
      resp_no_resources <= 1'b0;
    end else begin
      resp_ack <= acb_accept || prm_ok;
      resp_no_resources <= nores;
      case (state_reg)
        ST_IDLE: begin
          idx_reg <= 8'h00;
          ovf_reg <= 1'b0;
          svc_reg <= rx_service;
          if (rx_start) begin
            if ((rx_service == `SVC_ADDR) && (acb_ptr_reg == 8'h00)) begin
              state_reg <= ST_DROP;
            end else begin
              state_reg <= ST_RECV;
            end
          end
        end
        ST_RECV: begin
          if (rx_valid) begin
            if (idx_reg < cap) begin
              idx_reg <= idx_reg + 8'h01;
            end else begin
              ovf_reg <= 1'b1;
            end
          end
          if (rx_end) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_DROP: begin
          if (rx_end) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
  // registers written by software or by accepted telegrams
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acb_ptr_reg <= 8'h00;
      station_reg <= 8'h00;
      nochg_reg <= 8'h00;
      acb_len_reg <= 8'h00;
      prm_len_reg <= 8'h00;
      acb_cap_reg <= `CAP_RESET;
      prm_cap_reg <= `CAP_RESET;
      ssa_pending_reg <= 1'b0;
      prm_pending_reg <= 1'b0;
    end else begin
      if (wr_acc && (paddr == `OFS_ACB_PTR)) begin
        acb_ptr_reg <= pwdata[7:0];
      end
      if (wr_acc && (paddr == `OFS_CAPACITY)) begin
        acb_cap_reg <= (pwdata[7:0] > `BUF_DEPTH) ? `BUF_DEPTH : pwdata[7:0];
        prm_cap_reg <= (pwdata[15:8] > `BUF_DEPTH) ? `BUF_DEPTH : pwdata[15:8];
      end
      if (acb_accept) begin
        station_reg <= shadow[`ACB_NEW_ADDR];
        nochg_reg <= shadow[`ACB_NOCHG];
        acb_len_reg <= idx_reg;
      end else begin
        if (wr_acc && (paddr == `OFS_STATION)) begin
          station_reg <= pwdata[7:0];
        end
        if (wr_acc && (paddr == `OFS_NOCHG)) begin
          nochg_reg <= pwdata[7:0];
        end
      end
      if (acb_accept) begin
        ssa_pending_reg <= 1'b1;
      end else if (release_rd) begin
        ssa_pending_reg <= 1'b0;
      end
      if (prm_swap) begin
        prm_len_reg <= idx_reg;
        prm_pending_reg <= 1'b1;
      end else if (prm_ack_rd) begin
        prm_pending_reg <= 1'b0;
      end
    end
  end
  // parameter decode on every accepted parameter telegram
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prm_status_reg <= 8'h00;
      f1_reg <= 8'h01;
      f2_reg <= 8'h01;
      min_responder_delay_reg <= 8'h00;
      ident_reg <= 16'h0000;
      group_reg <= 8'h00;
      spec_reg <= 8'h00;
      ext2_reg <= 8'h00;
      ext3_reg <= 8'h00;
    end else if (prm_ok) begin
      prm_status_reg <= shadow[`PRM_STATUS];
      f1_reg <= shadow[`PRM_F1];
      f2_reg <= shadow[`PRM_F2];
      min_responder_delay_reg <= shadow[`PRM_MIN_RESPONDER_DELAY];
      ident_reg <= {shadow[`PRM_ID_HI], shadow[`PRM_ID_LO]};
      group_reg <= shadow[`PRM_GROUP];
      spec_reg <= spec_new;
      if (spec_new[`SPEC_EXT_EN] && (idx_reg > `PRM_EXT3)) begin
        ext2_reg <= shadow[`PRM_EXT2];
        ext3_reg <= shadow[`PRM_EXT3];
      end else begin
        ext2_reg <= 8'h00;
        ext3_reg <= 8'h00;
      end
    end
  end

  assign extensions_enable = spec_reg[`SPEC_EXT_EN];
  assign fail_safe_enable = spec_reg[`SPEC_FAILSAFE];
  assign publisher_enable = spec_reg[`SPEC_PUBLISHER];
  assign watchdog_time_base = spec_reg[`SPEC_WATCHDOG_TIME_BASE];
  assign stop_check_disable = spec_reg[`SPEC_NO_STOP];
  assign start_check_disable = spec_reg[`SPEC_NO_START];
  assign response_monitoring = prm_status_reg[`STAT_WATCHDOG_ENABLE_BIT];
  assign station_address = station_reg;
  assign no_change_flag = nochg_reg;
  assign new_address_data_interrupt = ssa_pending_reg;
  assign new_prm_data_interrupt = prm_pending_reg;
  // apb read mux and address decode
  always @* begin
    rd_mux = 32'h00000000;
    mapped = 1'b1;
    if (win == `WIN_ACB) begin
      mapped = win_ok;
      rd_mux = {24'h000000, acb_rd};
    end else if (win == `WIN_PRM) begin
      mapped = win_ok;
      rd_mux = {24'h000000, prm_rd};
    end else begin
      case (paddr)
        `OFS_ACB_PTR: rd_mux = {24'h000000, acb_ptr_reg};
        `OFS_STATION: rd_mux = {24'h000000, station_reg};
        `OFS_NOCHG: rd_mux = {24'h000000, nochg_reg};
        `OFS_ACB_LEN: rd_mux = {24'h000000, acb_len_reg};
        `OFS_STATUS: rd_mux = {28'h0000000, response_monitoring, ssa_pending_reg,
          prm_pending_reg, ssa_pending_reg};
        `OFS_RELEASE: rd_mux = 32'h00000000;
        `OFS_PRM_LEN: rd_mux = {24'h000000, prm_len_reg};
        `OFS_PRM_DECODE: rd_mux = {group_reg, min_responder_delay_reg, spec_reg, prm_status_reg};
        `OFS_WD_FACT: rd_mux = {16'h0000, f2_reg, f1_reg};
        `OFS_IDENT: rd_mux = {16'h0000, ident_reg};
        `OFS_EXT_STATUS: rd_mux = {16'h0000, ext3_reg, ext2_reg};
        `OFS_PRM_ACK: rd_mux = 32'h00000000;
        `OFS_CAPACITY: rd_mux = {16'h0000, prm_cap_reg, acb_cap_reg};
        default: mapped = 1'b0;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else if (setup) begin
      prdata_reg <= rd_mux;
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
endmodule // slave_address_param_service

/* File: common/slave_service_regs.vh */
// constants of the address-change and parameter telegram service
// included by the rtl files; apb byte addresses, 12-bit address bus
`ifndef SLAVE_SERVICE_REGS_VH
`define SLAVE_SERVICE_REGS_VH
`define OFS_ACB_PTR 12'h000
`define OFS_STATION 12'h004
`define OFS_NOCHG 12'h008
`define OFS_ACB_LEN 12'h00c
`define OFS_STATUS 12'h010
`define OFS_RELEASE 12'h014
`define OFS_PRM_LEN 12'h018
`define OFS_PRM_DECODE 12'h01c
`define OFS_WD_FACT 12'h020
`define OFS_IDENT 12'h024
`define OFS_EXT_STATUS 12'h028
`define OFS_PRM_ACK 12'h02c
`define OFS_CAPACITY 12'h030
`define WIN_ACB 2'h1
`define WIN_PRM 2'h2
`define BUF_DEPTH 8'hf4
`define BUF_DEPTH_9 9'h0f4
`define CAP_RESET 8'hf4
`define SVC_ADDR 1'b0
`define SVC_PRM 1'b1
`define ACB_NEW_ADDR 0
`define ACB_ID_HI 1
`define ACB_ID_LO 2
`define ACB_NOCHG 3
`define PRM_BASE_LEN 8'h07
`define PRM_STATUS 0
`define PRM_F1 1
`define PRM_F2 2
`define PRM_MIN_RESPONDER_DELAY 3
`define PRM_ID_HI 4
`define PRM_ID_LO 5
`define PRM_GROUP 6
`define PRM_SPEC 7
`define PRM_EXT2 8
`define PRM_EXT3 9
`define PRM_SHADOW 10
`define SPEC_EXT_EN 7
`define SPEC_FAILSAFE 6
`define SPEC_PUBLISHER 5
`define SPEC_WATCHDOG_TIME_BASE 2
`define SPEC_NO_STOP 1
`define SPEC_NO_START 0
`define STAT_WATCHDOG_ENABLE_BIT 3
`define WATCHDOG_TIME_BASE_COARSE_MS 10
`define WATCHDOG_TIME_BASE_FINE_MS 1
`define CLK_PERIOD_NS 8
`define NS_PER_MS 1000000
// one millisecond of 8 ns cycles, sized to the divider width
`define WD_MS_CYCLES 17'h1e848
`endif

/* File: rtl/swap_buffer.v */
// two banks of byte storage: one receives a telegram, the other is read
// assumes the caller keeps indices below the bank depth
`timescale 1ns/1ns
`include "slave_service_regs.vh"
module swap_buffer (
  input wire pclk,
  input wire presetn,
  input wire wr_en,
  input wire [7:0] wr_idx,
  input wire [7:0] wr_data,
  input wire swap,
  input wire [7:0] rd_idx,
  output wire [7:0] rd_data
);
  reg [7:0] mem [0:2*`BUF_DEPTH-1];
  reg bank_reg;
  // bank_reg names the bank the host reads; the other one receives
  wire [8:0] wa = bank_reg ? {1'b0, wr_idx} : ({1'b0, wr_idx} + `BUF_DEPTH_9);
  wire [8:0] ra = bank_reg ? ({1'b0, rd_idx} + `BUF_DEPTH_9) : {1'b0, rd_idx};

  always @(posedge pclk) begin
    if (wr_en) begin
      mem[wa] <= wr_data;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_reg <= 1'b0;
    end else if (swap) begin
      bank_reg <= ~bank_reg;
    end
  end

  assign rd_data = mem[ra];
endmodule // swap_buffer

/* File: rtl/monitor_timer.v */
// master monitoring timer: timeout = time base * factor one * factor two
// assumes factors are loaded from an accepted parameter telegram
`timescale 1ns/1ns
`include "slave_service_regs.vh"
module monitor_timer #(
  parameter [16:0] MS_CYCLES = `WD_MS_CYCLES
) (
  input wire pclk,
  input wire presetn,
  input wire enable,
  input wire fine_base,
  input wire [7:0] factor_one,
  input wire [7:0] factor_two,
  input wire retrigger,
  output reg timeout
);
  reg [16:0] div_reg;
  reg [19:0] ms_reg;
  // base constants are 32 bits wide; only the low bits carry milliseconds
  wire [31:0] base_ms = fine_base ? `WATCHDOG_TIME_BASE_FINE_MS : `WATCHDOG_TIME_BASE_COARSE_MS;
  wire [19:0] base = base_ms[19:0];
  wire [19:0] limit = {12'h000, factor_one} * {12'h000, factor_two} * base;
  wire tick = (div_reg == MS_CYCLES - 17'h00001);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 17'h00000;
      ms_reg <= 20'h00000;
      timeout <= 1'b0;
    end else begin
      timeout <= 1'b0;
      if (!enable || retrigger) begin
        div_reg <= 17'h00000;
        ms_reg <= 20'h00000;
      end else if (tick) begin
        div_reg <= 17'h00000;
        if (ms_reg + 20'h00001 >= limit) begin
          ms_reg <= 20'h00000;
          timeout <= 1'b1;
        end else begin
          ms_reg <= ms_reg + 20'h00001;
        end
      end else begin
        div_reg <= div_reg + 17'h00001;
      end
    end
  end
endmodule // monitor_timer

/* File: tb/slave_address_param_service_asserts.sv */
// port checker for the address-change and parameter telegram service
// bound to every instance of the service; one clock, async low reset
`timescale 1ns/1ns
`include "slave_service_regs.vh"
module slave_address_param_service_asserts (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire rx_end,
  input wire rx_good,
  input wire resp_ack,
  input wire resp_no_resources,
  input wire new_address_data_interrupt,
  input wire new_prm_data_interrupt,
  input wire [7:0] station_address,
  input wire extensions_enable,
  input wire response_monitoring,
  input wire wd_timeout
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  sequence s_rel;
    acc && !pwrite && paddr == `OFS_RELEASE && !rx_end;
  endsequence
  sequence s_pack;
    acc && !pwrite && paddr == `OFS_PRM_ACK && !rx_end;
  endsequence
  a_ready_high: assert property (pready) else $error("pready low");
  a_release_zero: assert property (acc && !pwrite && paddr == `OFS_RELEASE |-> prdata == 32'h0 && !pslverr)
    else $error("release read not zero");
  a_release_clears: assert property (s_rel |=> !new_address_data_interrupt)
    else $error("address flag not cleared");
  a_prm_clears: assert property (s_pack |=> !new_prm_data_interrupt)
    else $error("parameter flag not cleared");
  a_bad_silent: assert property (rx_end && !rx_good |=> !resp_ack && !resp_no_resources)
    else $error("faulty telegram answered");
  a_flag_with_ack: assert property ($rose(new_address_data_interrupt) |-> resp_ack)
    else $error("address flag without ack");
  a_station_cause: assert property ($changed(station_address) |->
    $past(rx_end) || $past(acc && pwrite && paddr == `OFS_STATION))
    else $error("station address changed without cause");
  a_spec_cause: assert property ($changed(extensions_enable) |-> $past(rx_end))
    else $error("extension bit changed without telegram");
  a_wd_monitor: assert property ($rose(wd_timeout) |-> response_monitoring ##1 !wd_timeout)
    else $error("timeout outside monitoring");
  a_resp_single: assert property (resp_ack |-> !resp_no_resources ##1 !resp_ack)
    else $error("response not a single pulse");
endmodule // slave_address_param_service_asserts
bind slave_address_param_service slave_address_param_service_asserts chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .rx_end, .rx_good, .resp_ack, .resp_no_resources,
  .new_address_data_interrupt, .new_prm_data_interrupt, .station_address, .extensions_enable,
  .response_monitoring, .wd_timeout);

/* File: tb/telegram_master.sv */
// bus master station model: sends payload-only telegrams, reads the answer
// assumes the receiver samples on the rising edge of pclk
`timescale 1ns/1ns
module telegram_master (
  input wire pclk,
  input wire resp_ack,
  input wire resp_no_resources,
  output logic rx_start = 1'b0,
  output logic rx_service = 1'b0,
  output logic rx_valid = 1'b0,
  output logic [7:0] rx_data = 8'h00,
  output logic rx_end = 1'b0,
  output logic rx_good = 1'b0
);
  task send(input logic svc, good, input int n, input logic [7:0] b [0:11], output logic ack, nores);
    @(posedge pclk);
    rx_start <= 1'b1;
    rx_service <= svc;
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      rx_start <= 1'b0;
      rx_valid <= 1'b1;
      rx_data <= b[i];
    end
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
    rx_end <= 1'b1;
    rx_good <= good;
    @(posedge pclk);
    rx_end <= 1'b0;
    rx_good <= ~good;
    rx_service <= ~svc;
    @(negedge pclk);
    ack = resp_ack;
    nores = resp_no_resources;
  endtask
endmodule // telegram_master

/* File: tb/slave_address_param_service_tb.sv */
// testbench: apb host tasks and a telegram master drive the service
// assumes a 125 MHz pclk and a shortened 1 ms divider
`timescale 1ns/1ns
`include "slave_service_regs.vh"
module slave_address_param_service_tb;
  localparam int MS = 10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rdv;
  logic er, ack, nores;
  logic [7:0] pay [0:11];
  int failures = 0;
  int comparisons = 0;
  int k;
  wire [31:0] prdata;
  wire pready, pslverr, rx_start, rx_service, rx_valid, rx_end, rx_good, resp_ack, resp_no_resources;
  wire new_address_data_interrupt, new_prm_data_interrupt, extensions_enable, fail_safe_enable;
  wire publisher_enable, watchdog_time_base, stop_check_disable, start_check_disable;
  wire response_monitoring, wd_timeout;
  wire [7:0] rx_data, station_address, no_change_flag;
  wire [5:0] spec = {extensions_enable, fail_safe_enable, publisher_enable, watchdog_time_base,
    stop_check_disable, start_check_disable};
  always #4 pclk = ~pclk;
  slave_address_param_service #(.MS_CYCLES(17'h0000a)) uut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_start, .rx_service, .rx_valid, .rx_data, .rx_end,
    .rx_good, .resp_ack, .resp_no_resources, .new_address_data_interrupt, .new_prm_data_interrupt,
    .station_address, .no_change_flag, .extensions_enable, .fail_safe_enable, .publisher_enable,
    .watchdog_time_base, .stop_check_disable, .start_check_disable, .response_monitoring, .wd_timeout);
  telegram_master m (.pclk, .resp_ack, .resp_no_resources, .rx_start, .rx_service, .rx_valid,
    .rx_data, .rx_end, .rx_good);
  task results;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task cmp(input logic [31:0] g, e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      $display("BAD %0t bus hang", $time);
      results;
    end
    rdv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // a write lands on the access edge; let it settle before outputs are looked at
    @(negedge pclk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    cmp(rdv, e);
    cmp(er, ee);
  endtask
  task tel(input logic svc, good, input int n, input logic a_e, nr_e);
    m.send(svc, good, n, pay, ack, nores);
    cmp({ack, nores}, {a_e, nr_e});
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(`OFS_ACB_PTR, 32'h0, 1'b0);
    rd(`OFS_CAPACITY, 32'h0000f4f4, 1'b0);
    rd(12'h040, 32'h0, 1'b1);
    apb(1'b1, `OFS_STATION, 32'h05);
    apb(1'b1, `OFS_NOCHG, 32'hff);
    cmp({station_address, no_change_flag}, 16'h05ff);
    pay = '{8'h23, 8'h12, 8'h34, 8'h00, 8'h55, 8'h66, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    apb(1'b1, `OFS_ACB_PTR, 32'h0);
    tel(1'b0, 1'b1, 5, 1'b0, 1'b0);
    cmp(station_address, 8'h05);
    apb(1'b1, `OFS_ACB_PTR, 32'h01);
    tel(1'b0, 1'b1, 5, 1'b1, 1'b0);
    cmp({new_address_data_interrupt, station_address, no_change_flag}, 17'h12300);
    rd(`OFS_ACB_LEN, 32'h5, 1'b0);
    rd(`OFS_STATUS, 32'h5, 1'b0);
    for (int i = 0; i < 5; i++)
      rd(12'h400 + 12'(4 * i), {24'h0, pay[i]}, 1'b0);
    tel(1'b0, 1'b1, 5, 1'b0, 1'b1);
    rd(`OFS_RELEASE, 32'h0, 1'b0);
    cmp(new_address_data_interrupt, 1'b0);
    pay[0] = 8'h41;
    tel(1'b0, 1'b0, 5, 1'b0, 1'b0);
    cmp({new_address_data_interrupt, station_address}, 9'h023);
    apb(1'b1, `OFS_CAPACITY, 32'h0000f404);
    tel(1'b0, 1'b1, 5, 1'b0, 1'b1);
    cmp(station_address, 8'h23);
    apb(1'b1, `OFS_CAPACITY, 32'h0000f4f4);
    pay = '{8'h08, 8'h02, 8'h03, 8'h0b, 8'h12, 8'h34, 8'h01, 8'h00, 8'h5a, 8'ha5, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++) begin
      pay[7] = (i < 3) ? (8'h80 >> i) : (8'h04 >> (i - 3));
      tel(1'b1, 1'b1, 8, 1'b1, 1'b0);
      cmp({new_prm_data_interrupt, spec}, {1'b1, 6'h20 >> i});
      rd(`OFS_PRM_ACK, 32'h0, 1'b0);
      cmp(new_prm_data_interrupt, 1'b0);
    end
    rd(`OFS_PRM_LEN, 32'h8, 1'b0);
    rd(`OFS_PRM_DECODE, 32'h010b0108, 1'b0);
    rd(`OFS_WD_FACT, 32'h0302, 1'b0);
    rd(`OFS_IDENT, 32'h1234, 1'b0);
    rd(12'h81c, 32'h01, 1'b0);
    cmp(response_monitoring, 1'b1);
    tel(1'b1, 1'b1, 7, 1'b1, 1'b0);
    cmp({new_prm_data_interrupt, spec}, 7'h00);
    pay[7] = 8'h80;
    pay[10] = 8'h3c;
    pay[11] = 8'hc3;
    tel(1'b1, 1'b1, 12, 1'b1, 1'b0);
    rd(`OFS_EXT_STATUS, 32'ha55a, 1'b0);
    rd(12'h828, 32'h3c, 1'b0);
    pay[7] = 8'h04;
    tel(1'b1, 1'b1, 8, 1'b1, 1'b0);
    k = 0;
    while (wd_timeout !== 1'b1 && k < 200) begin
      @(negedge pclk);
      k++;
    end
    cmp(k >= 6 * MS - 4 && k <= 6 * MS + 4, 1'b1);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    cmp({response_monitoring, spec}, 7'h00);
    results;
  end
endmodule // slave_address_param_service_tb
